// [src/lsau_core.sv]
`timescale 1ns/1ps
// What this block does
// - indexed address: base plus offset shifted 0..3
// - byte, half, word; signed or unsigned loads
// - zero or sign extend loads to 32
// - indexed operand register restrictions reported as bad encoding
// - load to pc branches with bit0 cleared
// - condition flags never written
// - user form: base plus immediate 0..255
// - user form always unprivileged on bus
// - user form otherwise like immediate transfer
// - user form base and transfer restrictions
// - pc-relative offset ranges checked
// - two-word pc-relative destination restrictions
// - increment_after: upward words, ascending registers
// - decrement_before: downward words, descending registers
// - writeback stores final accessed address
// - missing mode means increment_after
// - stack aliases map to base modes
// - multiple transfers move words only
// - multiple transfer list and base restrictions
// - empty register list is invalid
module lsau_core (
	// clock and reset
	input  wire logic                  i_clk,
	input  wire logic                  i_rst_b,
	// decoded instruction
	input  wire logic                  i_valid,
	input  wire lsau_pkg::lsau_form_t  i_form,
	input  wire logic                  i_load,
	input  wire lsau_pkg::lsau_size_t  i_size,
	input  wire logic                  i_signed,
	input  wire logic                  i_two_word,
	input  wire logic [3:0]            i_rt,
	input  wire logic [3:0]            i_rt2,
	input  wire logic [3:0]            i_rn,
	input  wire logic [3:0]            i_rm,
	input  wire logic [1:0]            i_shift,
	input  wire logic [11:0]           i_imm,
	input  wire logic                  i_sub,
	input  wire lsau_pkg::lsau_mmode_t i_mmode,
	input  wire logic                  i_wback,
	input  wire logic [15:0]           i_reglist,
	// register file view
	input  wire logic [511:0]          i_reg_file,
	input  wire logic [31:0]           i_pc_val,
	// memory answer
	input  wire logic                  i_mem_ack,
	input  wire logic [31:0]           i_mem_rdata,
	// pipeline status
	output logic                       o_ready,
	output logic                       o_done,
	output logic                       o_bad_enc,
	output logic                       o_flag_we,
	// memory request
	output logic                       o_mem_req,
	output logic                       o_mem_write,
	output lsau_pkg::lsau_size_t       o_mem_size,
	output logic                       o_mem_unpriv,
	output logic [31:0]                o_mem_addr,
	output logic [31:0]                o_mem_wdata,
	// register write and branch
	output logic                       o_reg_we,
	output logic [3:0]                 o_reg_idx,
	output logic [31:0]                o_reg_wdata,
	output logic                       o_branch,
	output logic [31:0]                o_branch_addr
);

	// ****************************************
	// helpers
	// ****************************************
	typedef enum logic [1:0] {st_idle, st_access, st_fin} lsau_state_t;

	// last hit wins: highest set bit when descending, lowest otherwise
	function automatic logic [3:0] lsau_pick(input logic [15:0] mask, input logic desc);
		logic [3:0] r;
		r = 4'h0;
		for (int k = 0; k < 16; k++) begin
			if (mask[desc ? k : 15 - k]) r = desc ? 4'(k) : 4'(15 - k);
		end
		return r;
	endfunction

	function automatic logic [31:0] lsau_lanes(input logic [31:0] v, input lsau_pkg::lsau_size_t s);
		case (s)
			lsau_pkg::size_byte: return {4{v[7:0]}};
			lsau_pkg::size_half: return {2{v[15:0]}};
			default:             return v;
		endcase
	endfunction

	lsau_state_t          state_q;
	lsau_pkg::lsau_form_t form_q;
	logic                 load_q, sgn_q, two_q, second_q, desc_q, wback_q;
	logic [3:0]           rt2_q, rn_q, cur_q;
	logic [15:0]          mask_q;

	// ****************************************
	// accept and decode
	// ****************************************
	logic        accept, ack_now, is_multi, desc_d, bad_d, more;
	logic [3:0]  first_reg, next_reg;
	logic [15:0] mask_nxt;
	logic [31:0] rn_val, rm_val, idx_addr, user_addr, pcrel_addr, start_addr, next_addr, ext_val;

	assign accept   = i_valid & o_ready;
	assign ack_now  = (state_q == st_access) & i_mem_ack;
	assign is_multi = (i_form == lsau_pkg::form_multi);
	assign rn_val   = i_reg_file[{i_rn, 5'h00} +: 32];
	assign rm_val   = i_reg_file[{i_rm, 5'h00} +: 32];
	assign idx_addr   = rn_val + (rm_val << i_shift);
	assign user_addr  = rn_val + {24'h00_0000, i_imm[7:0]};
	assign pcrel_addr = i_sub ? i_pc_val - {20'h0_0000, i_imm}
	                          : i_pc_val + {20'h0_0000, i_imm};

	assign desc_d = i_mmode inside {lsau_pkg::decrement_before,
	                                lsau_pkg::empty_ascending_pop_alias,
	                                lsau_pkg::full_descending_push_alias};

	assign start_addr = (i_form == lsau_pkg::form_indexed) ? idx_addr
	                  : (i_form == lsau_pkg::form_user)    ? user_addr
	                  : (i_form == lsau_pkg::form_pc_rel)  ? pcrel_addr : rn_val;

	assign first_reg = is_multi ? lsau_pick(i_reglist, desc_d) : i_rt;

	// violations are reported, the access still runs (an empty list has none) so nothing can stall
	always_comb begin
		case (i_form)
			lsau_pkg::form_indexed: bad_d = (i_rn == lsau_pkg::REG_PC)
				| (i_rm == lsau_pkg::REG_SP) | (i_rm == lsau_pkg::REG_PC)
				| ((i_rt == lsau_pkg::REG_SP) & (i_size != lsau_pkg::size_word))
				| ((i_rt == lsau_pkg::REG_PC) & !(i_load & (i_size == lsau_pkg::size_word)))
				| (!i_load & i_signed);
			lsau_pkg::form_user: bad_d = (i_rn == lsau_pkg::REG_PC)
				| (i_rt == lsau_pkg::REG_SP) | (i_rt == lsau_pkg::REG_PC)
				| (i_imm[11:8] != lsau_pkg::USER_IMM_HI) | (!i_load & i_signed);
			lsau_pkg::form_pc_rel: bad_d = !i_load | (i_imm > lsau_pkg::PCREL_MAX)
				| (((i_rt == lsau_pkg::REG_SP) | (i_rt == lsau_pkg::REG_PC))
					& (i_size != lsau_pkg::size_word))
				| (i_two_word & ((i_rt == i_rt2) | (i_rt2 == lsau_pkg::REG_SP)
					| (i_rt2 == lsau_pkg::REG_PC) | (i_imm > lsau_pkg::PCREL_TWO_MAX)));
			default: bad_d = (i_rn == lsau_pkg::REG_PC) | i_reglist[lsau_pkg::REG_SP]
				| (!i_load & i_reglist[lsau_pkg::REG_PC])
				| (i_load & i_reglist[lsau_pkg::REG_PC] & i_reglist[lsau_pkg::REG_LR])
				| (i_wback & i_reglist[i_rn])
				| (i_reglist == lsau_pkg::LIST_EMPTY);
		endcase
	end

	// ****************************************
	// access sequencing
	// ****************************************
	assign mask_nxt  = mask_q & ~(16'h0001 << cur_q);
	assign more      = (form_q == lsau_pkg::form_multi) ? (mask_nxt != lsau_pkg::LIST_EMPTY)
	                                                    : (two_q & !second_q);
	assign next_reg  = (form_q == lsau_pkg::form_multi) ? lsau_pick(mask_nxt, desc_q) : rt2_q;
	assign next_addr = desc_q ? o_mem_addr - lsau_pkg::WORD_BYTES
	                          : o_mem_addr + lsau_pkg::WORD_BYTES;

	lsau_load_ext u_ext (
		.i_rdata  (i_mem_rdata),
		.i_lane   (o_mem_addr[1:0]),
		.i_size   (o_mem_size),
		.i_signed (sgn_q),
		.o_value  (ext_val)
	);

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state_q      <= st_idle;
			form_q       <= lsau_pkg::form_indexed;
			load_q       <= 1'b0;
			sgn_q        <= 1'b0;
			two_q        <= 1'b0;
			second_q     <= 1'b0;
			desc_q       <= 1'b0;
			wback_q      <= 1'b0;
			rt2_q        <= 4'h0;
			rn_q         <= 4'h0;
			cur_q        <= 4'h0;
			mask_q       <= 16'h0000;
			o_mem_req    <= 1'b0;
			o_mem_write  <= 1'b0;
			o_mem_size   <= lsau_pkg::size_word;
			o_mem_unpriv <= 1'b0;
			o_mem_addr   <= 32'h0000_0000;
			o_mem_wdata  <= 32'h0000_0000;
		end else begin
			case (state_q)
				st_idle: begin
					if (accept) begin
						form_q       <= i_form;
						load_q       <= i_load;
						sgn_q        <= i_load & i_signed;
						two_q        <= (i_form == lsau_pkg::form_pc_rel) & i_two_word;
						second_q     <= 1'b0;
						desc_q       <= is_multi & desc_d;
						wback_q      <= is_multi & i_wback & (i_reglist != lsau_pkg::LIST_EMPTY);
						rt2_q        <= i_rt2;
						rn_q         <= i_rn;
						cur_q        <= first_reg;
						mask_q       <= i_reglist;
						o_mem_req    <= !(is_multi & (i_reglist == lsau_pkg::LIST_EMPTY));
						o_mem_write  <= !i_load;
						o_mem_size   <= (is_multi | i_two_word) ? lsau_pkg::size_word
						                                        : i_size;
						o_mem_unpriv <= (i_form == lsau_pkg::form_user);
						o_mem_addr   <= start_addr;
						o_mem_wdata  <= lsau_lanes(i_reg_file[{first_reg, 5'h00} +: 32],
						                           is_multi ? lsau_pkg::size_word : i_size);
						state_q      <= (is_multi & (i_reglist == lsau_pkg::LIST_EMPTY))
						                ? st_fin : st_access;
					end
				end
				st_access: begin
					if (i_mem_ack) begin
						if (more) begin
							second_q    <= 1'b1;
							mask_q      <= mask_nxt;
							cur_q       <= next_reg;
							o_mem_addr  <= (form_q == lsau_pkg::form_multi) ? next_addr
							               : o_mem_addr + lsau_pkg::WORD_BYTES;
							o_mem_wdata <= i_reg_file[{next_reg, 5'h00} +: 32];
						end else begin
							o_mem_req <= 1'b0;
							state_q   <= st_fin;
						end
					end
				end
				st_fin: state_q <= st_idle;
				default: state_q <= st_idle;
			endcase
		end
	end

	// ****************************************
	// register write, branch, status
	// ****************************************
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_reg_we      <= 1'b0;
			o_reg_idx     <= 4'h0;
			o_reg_wdata   <= 32'h0000_0000;
			o_branch      <= 1'b0;
			o_branch_addr <= 32'h0000_0000;
		end else begin
			o_reg_we <= 1'b0;
			o_branch <= 1'b0;
			if (ack_now && load_q) begin
				if (cur_q == lsau_pkg::REG_PC) begin
					o_branch      <= 1'b1;
					o_branch_addr <= {i_mem_rdata[31:1], 1'b0};
				end else begin
					o_reg_we    <= 1'b1;
					o_reg_idx   <= cur_q;
					o_reg_wdata <= ext_val;
				end
			end else if (state_q == st_fin && wback_q) begin
				o_reg_we    <= 1'b1;
				o_reg_idx   <= rn_q;
				o_reg_wdata <= o_mem_addr;
			end
		end
	end

	// flags port stays low: nothing here may touch the condition flags
	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_ready   <= 1'b1;
			o_done    <= 1'b0;
			o_bad_enc <= 1'b0;
			o_flag_we <= 1'b0;
		end else begin
			o_flag_we <= 1'b0;
			o_bad_enc <= accept & bad_d;
			o_done    <= (state_q == st_fin);
			if (accept) begin
				o_ready <= 1'b0;
			end else if (state_q == st_fin) begin
				o_ready <= 1'b1;
			end
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	default clocking lsau_cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);

	a_flags_untouched: assert property (o_flag_we == 1'b0) else $error("flag write seen");
	a_branch_halfword: assert property (ack_now && load_q && cur_q == lsau_pkg::REG_PC
		|=> o_branch && o_branch_addr == {$past(i_mem_rdata[31:1]), 1'b0} && !o_reg_we)
		else $error("pc load did not branch to cleared address");
	a_index_addr: assert property (accept && i_form == lsau_pkg::form_indexed
		|=> o_mem_req && o_mem_addr == $past(idx_addr))
		else $error("indexed address wrong");
	a_user_addr_unpriv: assert property (accept && i_form == lsau_pkg::form_user
		|=> o_mem_unpriv && o_mem_addr == $past(rn_val) + {24'h00_0000, $past(i_imm[7:0])})
		else $error("user transfer address or attribute wrong");
	a_user_unpriv_held: assert property (o_mem_req && form_q == lsau_pkg::form_user
		|-> o_mem_unpriv)
		else $error("user transfer not unprivileged");
	a_multi_word_size: assert property (o_mem_req && form_q == lsau_pkg::form_multi
		|-> o_mem_size == lsau_pkg::size_word)
		else $error("multiple transfer not word sized");
	a_multi_up_step: assert property (ack_now && more && form_q == lsau_pkg::form_multi
		&& !desc_q |=> o_mem_req && o_mem_addr == $past(o_mem_addr) + lsau_pkg::WORD_BYTES
		&& cur_q > $past(cur_q))
		else $error("ascending step wrong");
	a_multi_down_step: assert property (ack_now && more && form_q == lsau_pkg::form_multi
		&& desc_q |=> o_mem_req && o_mem_addr == $past(o_mem_addr) - lsau_pkg::WORD_BYTES
		&& cur_q < $past(cur_q))
		else $error("descending step wrong");
	a_wback_final: assert property (state_q == st_fin && wback_q
		|=> o_reg_we && o_reg_idx == rn_q && o_reg_wdata == o_mem_addr && o_done)
		else $error("writeback wrong");
	a_single_no_wb: assert property (o_done && form_q != lsau_pkg::form_multi
		|-> !o_reg_we)
		else $error("single form wrote base");
	a_empty_list_done: assert property (accept && is_multi
		&& i_reglist == lsau_pkg::LIST_EMPTY |=> !o_mem_req ##1 o_done && o_ready)
		else $error("empty list did not finish cleanly");
	a_store_no_ext: assert property (accept && !i_load |=> o_mem_write && !sgn_q)
		else $error("signed store variant leaked");

	c_indexed_load:  cover property (ack_now && load_q && form_q == lsau_pkg::form_indexed);
	c_multi_wback:   cover property (state_q == st_fin && wback_q);
	c_pc_branch:     cover property (o_branch);
	c_two_word_load: cover property (ack_now && two_q && second_q);

endmodule

// [include/lsau_pkg.sv]
package lsau_pkg;

	// ****************************************
	// instruction forms and fields
	// ****************************************
	typedef enum logic [1:0] {
		form_indexed,
		form_user,
		form_pc_rel,
		form_multi
	} lsau_form_t;

	typedef enum logic [1:0] {
		size_byte,
		size_half,
		size_word
	} lsau_size_t;

	// mode_none is what the pipeline sends when no mode was encoded
	typedef enum logic [2:0] {
		mode_none,
		increment_after,
		decrement_before,
		full_descending_pop_alias,
		empty_ascending_pop_alias,
		empty_ascending_push_alias,
		full_descending_push_alias
	} lsau_mmode_t;

	// ****************************************
	// register numbers and constants
	// ****************************************
	localparam logic [3:0]  REG_SP        = 4'hD;
	localparam logic [3:0]  REG_LR        = 4'hE;
	localparam logic [3:0]  REG_PC        = 4'hF;
	localparam logic [31:0] WORD_BYTES    = 32'h0000_0004;
	localparam logic [3:0]  USER_IMM_HI   = 4'h0;
	localparam logic [11:0] PCREL_MAX     = 12'hFFF;
	localparam logic [11:0] PCREL_TWO_MAX = 12'h3FC;
	localparam logic [15:0] LIST_EMPTY    = 16'h0000;

endpackage

// [src/lsau_load_ext.sv]
`timescale 1ns/1ps
module lsau_load_ext (
	// loaded word and lane
	input  wire logic [31:0]         i_rdata,
	input  wire logic [1:0]          i_lane,
	// transfer shape
	input  wire lsau_pkg::lsau_size_t i_size,
	input  wire logic                i_signed,
	// extended result
	output logic      [31:0]         o_value
);

	logic [7:0]  byte_v;
	logic [15:0] half_v;

	assign byte_v = i_rdata[{i_lane, 3'h0} +: 8];
	assign half_v = i_lane[1] ? i_rdata[31:16] : i_rdata[15:0];

	always_comb begin
		case (i_size)
			lsau_pkg::size_byte: o_value = {{24{i_signed & byte_v[7]}}, byte_v};
			lsau_pkg::size_half: o_value = {{16{i_signed & half_v[15]}}, half_v};
			default:             o_value = i_rdata;
		endcase
	end

endmodule

// [dv/lsau_mem_model.sv]
`timescale 1ns/1ps
module lsau_mem_model (
	// clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rst_b,
	// request from the block
	input  wire logic        i_req,
	input  wire logic [31:0] i_addr,
	input  wire logic [1:0]  i_wait,
	// answer to the block
	output logic             o_ack,
	output logic [31:0]      o_rdata
);
	logic [1:0]  cnt_q;
	logic [31:0] last_q;
	logic [31:0] word;

	// ****************************************
	// contents: fixed function of word address
	// ****************************************
	// bit 0 kept set so any word is a legal pc load
	assign word    = {~i_addr[17:2], i_addr[17:3], 1'b1};
	// i_wait 0 answers in the request cycle, 3 is slow
	assign o_ack   = i_req && (cnt_q == i_wait);
	// no stale data shown outside an answer
	assign o_rdata = o_ack ? word : ~last_q;

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cnt_q <= 2'h0;
		end else if (o_ack) begin
			cnt_q <= 2'h0;
		end else if (i_req) begin
			cnt_q <= cnt_q + 2'h1;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			last_q <= 32'h0000_0000;
		end else if (o_ack) begin
			last_q <= word;
		end
	end
endmodule

// [dv/load_store_address_unit_test.sv]
`timescale 1ns/1ps
module load_store_address_unit_test;
	// ****************************************
	// signals
	// ****************************************
	logic                  i_clk, i_rst_b, i_valid, i_load, i_signed, i_two_word, i_sub;
	logic                  i_wback, i_mem_ack, o_ready, o_done, o_bad_enc, o_flag_we;
	logic                  o_mem_req, o_mem_write, o_mem_unpriv, o_reg_we, o_branch, bad_seen;
	lsau_pkg::lsau_form_t  i_form;
	lsau_pkg::lsau_size_t  i_size, o_mem_size;
	lsau_pkg::lsau_mmode_t i_mmode;
	logic [3:0]            i_rt, i_rt2, i_rn, i_rm, o_reg_idx;
	logic [1:0]            i_shift, mwait;
	logic [11:0]           i_imm;
	logic [15:0]           i_reglist;
	logic [511:0]          i_reg_file;
	logic [31:0]           i_pc_val, i_mem_rdata, o_mem_addr, o_mem_wdata, o_reg_wdata;
	logic [31:0]           o_branch_addr;
	logic [67:0]           mq[$];
	logic [36:0]           rq[$];
	logic                  bq[$];
	int                    fail_count, checked, it, k;
	integer                seed = 32'h0000_99ff;

	lsau_core DUT (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_valid(i_valid), .i_form(i_form),
		.i_load(i_load), .i_size(i_size), .i_signed(i_signed), .i_two_word(i_two_word),
		.i_rt(i_rt), .i_rt2(i_rt2), .i_rn(i_rn), .i_rm(i_rm), .i_shift(i_shift), .i_imm(i_imm),
		.i_sub(i_sub), .i_mmode(i_mmode), .i_wback(i_wback), .i_reglist(i_reglist),
		.i_reg_file(i_reg_file), .i_pc_val(i_pc_val), .i_mem_ack(i_mem_ack),
		.i_mem_rdata(i_mem_rdata), .o_ready(o_ready), .o_done(o_done), .o_bad_enc(o_bad_enc),
		.o_flag_we(o_flag_we), .o_mem_req(o_mem_req), .o_mem_write(o_mem_write),
		.o_mem_size(o_mem_size), .o_mem_unpriv(o_mem_unpriv), .o_mem_addr(o_mem_addr),
		.o_mem_wdata(o_mem_wdata), .o_reg_we(o_reg_we), .o_reg_idx(o_reg_idx),
		.o_reg_wdata(o_reg_wdata), .o_branch(o_branch), .o_branch_addr(o_branch_addr));

	lsau_mem_model MEM (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_req(o_mem_req),
		.i_addr(o_mem_addr), .i_wait(mwait), .o_ack(i_mem_ack), .o_rdata(i_mem_rdata));

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [31:0] rv(input logic [3:0] n);
		return i_reg_file[32*n +: 32];
	endfunction

	function automatic logic [31:0] mw(input logic [31:0] a);
		return {~a[17:2], a[17:3], 1'b1};
	endfunction

	task automatic chk(input string what, input logic [67:0] exp_v, got_v);
		checked++;
		if (got_v !== exp_v) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", what, exp_v, got_v);
		end
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic put_acc(input logic wr, input lsau_pkg::lsau_size_t sz, input logic up,
		input logic [31:0] a, input logic [31:0] v);
		logic [31:0] d;
		d = (sz == lsau_pkg::size_byte) ? {4{v[7:0]}} : (sz == lsau_pkg::size_half) ? {2{v[15:0]}} : v;
		mq.push_back({wr, sz, up, a, wr ? d : 32'h0000_0000});
	endtask

	task automatic put_ld(input logic [3:0] idx, input logic [31:0] w, input logic [1:0] ln,
		input lsau_pkg::lsau_size_t sz, input logic sg);
		logic [7:0]  b;
		logic [15:0] h;
		logic [31:0] v;
		b = w[8*ln +: 8];
		h = ln[1] ? w[31:16] : w[15:0];
		v = w;
		if (sz == lsau_pkg::size_byte) v = sg ? {{24{b[7]}}, b} : {24'h00_0000, b};
		if (sz == lsau_pkg::size_half) v = sg ? {{16{h[15]}}, h} : {16'h0000, h};
		rq.push_back({idx == lsau_pkg::REG_PC, idx, (idx == lsau_pkg::REG_PC) ? v & 32'hFFFF_FFFE : v});
	endtask

	// called at a falling edge with the block idle and fields set
	task automatic go();
		logic [31:0]          am, a, a2;
		logic [3:0]           idx;
		logic                 dn, bad;
		lsau_pkg::lsau_size_t sz;
		int                   n;
		am = (i_size == lsau_pkg::size_half) ? 32'hFFFF_FFFE : 32'hFFFF_FFFF;
		if (i_size == lsau_pkg::size_word || i_two_word || i_form == lsau_pkg::form_multi)
			am = 32'hFFFF_FFFC;
		i_reg_file[32*i_rn +: 32] &= am;
		i_reg_file[32*i_rm +: 32] &= am;
		i_pc_val &= am;
		i_imm &= am[11:0];
		case (i_form)
			lsau_pkg::form_indexed: a = rv(i_rn) + (rv(i_rm) << i_shift);
			lsau_pkg::form_user: a = rv(i_rn) + {24'h00_0000, i_imm[7:0]};
			lsau_pkg::form_pc_rel: a = i_sub ? i_pc_val - {20'h0_0000, i_imm}
			                                 : i_pc_val + {20'h0_0000, i_imm};
			default: a = rv(i_rn);
		endcase
		bad = !i_load && i_signed;
		case (i_form)
			lsau_pkg::form_indexed: bad |= i_rm == lsau_pkg::REG_SP || i_rm == lsau_pkg::REG_PC ||
				(i_rt == lsau_pkg::REG_SP && i_size != lsau_pkg::size_word);
			lsau_pkg::form_user: bad |= i_rt == lsau_pkg::REG_SP;
			lsau_pkg::form_pc_rel: bad |= (i_two_word && (i_imm > lsau_pkg::PCREL_TWO_MAX ||
				i_rt == i_rt2 || i_rt2 == lsau_pkg::REG_SP)) || (!i_two_word &&
				i_rt == lsau_pkg::REG_SP && i_size != lsau_pkg::size_word);
			default: bad |= i_reglist[13] || (i_reglist[15] && i_reglist[14]) || i_reglist == 16'h0000;
		endcase
		bq.push_back(bad);
		if (i_form != lsau_pkg::form_multi) begin
			sz = i_two_word ? lsau_pkg::size_word : i_size;
			put_acc(!i_load, sz, i_form == lsau_pkg::form_user, a, rv(i_rt));
			if (i_load) put_ld(i_rt, mw(a), a[1:0], sz, i_signed);
			if (i_two_word) put_acc(1'b0, lsau_pkg::size_word, 1'b0, a + 32'h0000_0004, 32'h0000_0000);
			if (i_two_word) put_ld(i_rt2, mw(a + 32'h0000_0004), 2'h0, lsau_pkg::size_word, 1'b0);
		end else begin
			dn = i_mmode inside {lsau_pkg::decrement_before, lsau_pkg::empty_ascending_pop_alias,
				lsau_pkg::full_descending_push_alias};
			n = 0;
			for (int j = 0; j < 16; j++) begin
				idx = dn ? 4'(15 - j) : 4'(j);
				a2 = dn ? a - 32'(4 * n) : a + 32'(4 * n);
				if (i_reglist[idx]) put_acc(!i_load, lsau_pkg::size_word, 1'b0, a2, rv(idx));
				if (i_reglist[idx] && i_load) put_ld(idx, mw(a2), 2'h0, lsau_pkg::size_word, 1'b0);
				if (i_reglist[idx]) n++;
			end
			if (i_wback && n > 0)
				rq.push_back({1'b0, i_rn, dn ? a - 32'(4 * (n - 1)) : a + 32'(4 * (n - 1))});
		end
		i_valid = 1'b1;
		@(negedge i_clk);
		i_valid = 1'b0;
	endtask

	// ****************************************
	// clock, watchdog, output monitor
	// ****************************************
	initial begin
		i_clk = 1'b0;
		forever #4 i_clk = ~i_clk;
	end

	initial begin
		#(8 * 80000);
		fail_count++;
		$display("mismatch run length expected finished seen timeout");
		give_verdict();
	end

	always @(posedge i_clk) begin
		if (o_mem_req && i_mem_ack) begin
			chk("access", mq.size() ? mq.pop_front() : '1,
				{o_mem_write, o_mem_size, o_mem_unpriv, o_mem_addr,
				o_mem_write ? o_mem_wdata : 32'h0000_0000});
		end
		if (o_reg_we) chk("reg write", rq.size() ? rq.pop_front() : '1,
			{1'b0, o_reg_idx, o_reg_wdata});
		if (o_branch) chk("branch", rq.size() ? rq.pop_front() : '1, {1'b1, 4'hF, o_branch_addr});
		if (o_bad_enc) bad_seen = 1'b1;
		if (o_done) begin
			chk("bad flag", bq.size() ? bq.pop_front() : 1'bx,
				bad_seen);
			chk("leftover", 0, mq.size() + rq.size());
			chk("flag write", 0, o_flag_we);
			bad_seen = 1'b0;
		end
	end

	// ****************************************
	// stimulus
	// ****************************************
	initial begin
		{i_rst_b, i_valid, i_load, i_signed, i_two_word, i_sub, i_wback, bad_seen} = 8'h00;
		{i_rt, i_rt2, i_rn, i_rm, i_shift, mwait, i_imm, i_reglist} = 48'h0000_0000_0000;
		i_form = lsau_pkg::form_indexed;
		i_size = lsau_pkg::size_word;
		i_mmode = lsau_pkg::mode_none;
		i_reg_file = '0;
		i_pc_val = 32'h0000_0000;
		repeat (20) @(negedge i_clk);
		chk("reset outputs", 6'h20, {o_ready, o_done, o_mem_req, o_reg_we, o_branch, o_bad_enc});
		i_rst_b = 1'b1;
		for (it = 0; it < 400; it++) begin
			// wait for idle and the done pulse to pass
			k = 0;
			do begin
				@(negedge i_clk);
				k++;
			end while (!(o_ready === 1'b1 && o_done === 1'b0) && k < 300);
			if (k >= 300) chk("ready", 1, o_ready);
			for (int j = 0; j < 16; j++) i_reg_file[32*j +: 32] = $random(seed);
			i_pc_val = $random(seed);
			i_form = lsau_pkg::lsau_form_t'(2'($random(seed)));
			i_size = lsau_pkg::lsau_size_t'(2'($unsigned($random(seed)) % 3));
			i_mmode = lsau_pkg::lsau_mmode_t'(3'($unsigned($random(seed)) % 7));
			{i_load, i_signed, i_two_word, i_sub, i_wback, i_shift, mwait} = 9'($random(seed));
			{i_rt, i_rt2, i_rn, i_rm, i_imm, i_reglist} = 44'({$random(seed), $random(seed)});
			if (i_two_word) i_imm[11] = 1'b0;
			if (it == 0) i_form = lsau_pkg::form_multi;
			if (it == 0) i_reglist = 16'h0000;
			if (it == 1 || it == 2) i_form = lsau_pkg::form_pc_rel;
			if (it == 1 || it == 2) i_two_word = 1'b1;
			if (it == 1 || it == 2) i_imm = (it == 1) ? 12'h3FC : 12'h400;
			if (it == 3 || it == 4) i_form = lsau_pkg::form_user;
			if (it == 3 || it == 4) i_imm = (it == 3) ? 12'h0FF : 12'h000;
			// keep away from encodings whose data path is unspecified
			if (i_form != lsau_pkg::form_pc_rel) i_two_word = 1'b0;
			else i_load = 1'b1;
			if (i_form == lsau_pkg::form_user) i_imm[11:8] = 4'h0;
			if (i_rn == lsau_pkg::REG_PC) i_rn = 4'hE;
			if (i_size == lsau_pkg::size_word || i_two_word || i_form == lsau_pkg::form_multi)
				i_signed = 1'b0;
			if (i_rt == lsau_pkg::REG_PC && !(i_load && i_size == lsau_pkg::size_word &&
				i_form inside {lsau_pkg::form_indexed, lsau_pkg::form_pc_rel})) i_rt = 4'h1;
			if (i_two_word && i_rt >= lsau_pkg::REG_SP) i_rt = 4'h3;
			if (i_rt2 == lsau_pkg::REG_PC) i_rt2 = 4'hC;
			if (i_form == lsau_pkg::form_multi && !i_load) i_reglist[15] = 1'b0;
			if (i_form == lsau_pkg::form_multi && i_wback) i_reglist[i_rn] = 1'b0;
			go();
		end
		repeat (300) @(negedge i_clk);
		give_verdict();
	end
endmodule
